// *** pkg/cft_consts.vh ***
/*
 * holds offsets, field positions, opcodes, reset values and track geometry
 * of the cache-flush / track-format command block.
 * assumes inclusion by bare name from the executor under hdl/ and from the bench models.
 */
`ifndef CFT_CONSTS_VH
`define CFT_CONSTS_VH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define CFT_OP_FLUSH        8'he7
`define CFT_OP_FLUSH_EXT    8'hea
`define CFT_OP_FMT_TRACK    8'h50

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define CFT_A_ERROR         8'h00
`define CFT_A_SECNUM        8'h04
`define CFT_A_CYL_LO        8'h08
`define CFT_A_CYL_HI        8'h0c
`define CFT_A_DEVHEAD       8'h10
`define CFT_A_COMMAND       8'h14
`define CFT_A_STATUS        8'h18
`define CFT_A_IRQ_STAT      8'h1c
`define CFT_A_IRQ_MASK      8'h20
`define CFT_A_MAX_LBA       8'h24

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFT_ERR_ABT         2
`define CFT_ERR_IDN         4
`define CFT_ST_ERR          0
`define CFT_ST_DSC          4
`define CFT_ST_DF           5
`define CFT_ST_RDY          6
`define CFT_ST_BSY          7
`define CFT_DH_LBA          6
`define CFT_IRQ_DONE        0
`define CFT_IRQ_FAIL        1

// ----------------------------------------------------------------
// reset values and geometry
// ----------------------------------------------------------------
`define CFT_ST_RESET        8'h50
`define CFT_MAX_LBA_RESET   28'hfffffff
`define CFT_SEC_PER_TRK     8'h3f
`define CFT_HEADS           4'hf

`endif

// *** hdl/cft_sector_ram.v ***
/*
 * small write-cache memory: one dirty bit and an lba per slot.
 * assumes single clock; read data come out of a register one cycle on.
 */
`timescale 1ns/1ps
module cft_sector_ram #(
    parameter AW = 4,
    parameter DW = 29
) (
    input  wire          ref_clk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // registered read so the top sees a clean flop output
    always @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// *** hdl/cft_media_port.v ***
/*
 * media write sequencer: counts one sector per request and reports done.
 * assumes the media accepts a sector every SEC_CYC clocks, no read-back.
 */
`timescale 1ns/1ps
module cft_media_port #(
    parameter SEC_CYC = 8
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        start,
    input  wire [27:0] lba,
    input  wire        zero_fill,
    output reg         busy,
    output reg         done,
    output reg  [27:0] wr_lba,
    output reg         wr_zero
);
    reg [15:0] cnt;

    // fixed-latency write of one sector; no verify pass follows
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy    <= 1'b0;
            done    <= 1'b0;
            cnt     <= 16'h0000;
            wr_lba  <= 28'h0000000;
            wr_zero <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy    <= 1'b1;
                cnt     <= SEC_CYC[15:0];
                wr_lba  <= lba;
                wr_zero <= zero_fill;
            end else if (busy) begin
                if (cnt == 16'h0001) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt <= cnt - 16'h0001;
            end
        end
    end
endmodule

// *** hdl/cft_cmd_exec.v ***
/*
 * command executor for cache flush, extended flush and track format.
 * holds the task-file registers, a small write cache, and irq logic.
 * assumes a single 200 MHz clock and a same-clock register master.
 */
`timescale 1ns/1ps
`include "cft_consts.vh"
module cft_cmd_exec #(
    parameter CACHE_AW = 4,
    parameter SEC_CYC  = 8
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    input  wire        cache_put,
    input  wire [27:0] cache_lba,
    output reg  [31:0] rdata,
    output reg         irq,
    output reg         cache_full,
    output reg         media_we,
    output reg  [27:0] media_lba,
    output reg         media_zero
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam S_IDLE  = 3'd0;
    localparam S_FREAD = 3'd1;
    localparam S_FWAIT = 3'd2;
    localparam S_FMT   = 3'd3;
    localparam S_MWAIT = 3'd4;
    localparam S_DONE  = 3'd5;

    // ----------------------------------------------------------------
    // registers and nets
    // ----------------------------------------------------------------
    reg  [2:0]          state;
    reg  [7:0]          err_reg;
    reg  [7:0]          st_reg;
    reg  [7:0]          secnum;
    reg  [7:0]          cyl_lo;
    reg  [7:0]          cyl_hi;
    reg  [7:0]          devhead;
    reg  [1:0]          irq_stat;
    reg  [1:0]          irq_mask;
    reg  [27:0]         max_lba;
    reg  [27:0]         cur_lba;
    reg  [7:0]          sec_left;
    reg  [CACHE_AW-1:0] slot;
    reg  [CACHE_AW:0]   fill;
    reg  [CACHE_AW:0]   scan;
    reg                 m_start;
    reg  [1:0]          ev;
    wire [28:0]         ram_q;
    wire                m_busy;
    wire                m_done;
    wire [27:0]         m_lba;
    wire                m_zero;
    wire [27:0]         trk_lba;
    wire                cmd_wr;

    // first lba of the track holding a given address; the whole address is
    // reduced, since tracks do not line up with any byte boundary
    function [27:0] track_base;
        input [27:0] a;
        begin
            track_base = a - (a % {20'h00000, `CFT_SEC_PER_TRK});
        end
    endfunction

    // chs to lba, heads and sectors fixed by geometry
    function [27:0] chs_lba;
        input [15:0] c;
        input [3:0]  h;
        begin
            chs_lba = ({12'h000, c} * {24'h000000, `CFT_HEADS} + {24'h000000, h})
                      * {20'h00000, `CFT_SEC_PER_TRK};
        end
    endfunction

    // lba and chs track select
    assign trk_lba = devhead[`CFT_DH_LBA] ?
                     {devhead[3:0], cyl_hi, cyl_lo, secnum} :
                     chs_lba({cyl_hi, cyl_lo}, devhead[3:0]);
    assign cmd_wr = wr && (addr == `CFT_A_COMMAND) && !st_reg[`CFT_ST_BSY];

    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    cft_sector_ram #(.AW(CACHE_AW), .DW(29)) u_ram (
        .ref_clk (ref_clk),
        .we      (cache_put && !fill[CACHE_AW] && state == S_IDLE),
        .waddr   (fill[CACHE_AW-1:0]),
        .wdata   ({1'b1, cache_lba}),
        .raddr   (slot),
        .rdata   (ram_q)
    );

    cft_media_port #(.SEC_CYC(SEC_CYC)) u_media (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .start     (m_start),
        .lba       (cur_lba),
        .zero_fill (state == S_MWAIT && sec_left != 8'h00),
        .busy      (m_busy),
        .done      (m_done),
        .wr_lba    (m_lba),
        .wr_zero   (m_zero)
    );

    // ----------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= S_IDLE;
            err_reg  <= 8'h00;
            st_reg   <= `CFT_ST_RESET;
            secnum   <= 8'h00;
            cyl_lo   <= 8'h00;
            cyl_hi   <= 8'h00;
            devhead  <= 8'h00;
            max_lba  <= `CFT_MAX_LBA_RESET;
            cur_lba  <= 28'h0000000;
            sec_left <= 8'h00;
            slot     <= {CACHE_AW{1'b0}};
            fill     <= {(CACHE_AW+1){1'b0}};
            scan     <= {(CACHE_AW+1){1'b0}};
            m_start  <= 1'b0;
            ev       <= 2'b00;
        end else begin
            m_start <= 1'b0;
            ev      <= 2'b00;
            // cache intake only while idle, so a flush sees a fixed set
            if (cache_put && !fill[CACHE_AW] && state == S_IDLE) begin
                fill <= fill + 1'b1;
            end
            // address registers writable only while not busy
            if (wr && !st_reg[`CFT_ST_BSY]) begin
                if (addr == `CFT_A_SECNUM) begin
                    secnum <= wdata[7:0];
                end else if (addr == `CFT_A_CYL_LO) begin
                    cyl_lo <= wdata[7:0];
                end else if (addr == `CFT_A_CYL_HI) begin
                    cyl_hi <= wdata[7:0];
                end else if (addr == `CFT_A_DEVHEAD) begin
                    devhead <= wdata[7:0];
                end else if (addr == `CFT_A_MAX_LBA) begin
                    max_lba <= wdata[27:0];
                end
            end
            case (state)
                S_IDLE: begin
                    if (cmd_wr) begin
                        err_reg <= 8'h00;
                        if (wdata[7:0] == `CFT_OP_FLUSH || wdata[7:0] == `CFT_OP_FLUSH_EXT) begin
                            st_reg <= 8'h80;
                            slot   <= {CACHE_AW{1'b0}};
                            scan   <= {(CACHE_AW+1){1'b0}};
                            state  <= S_FREAD;
                        end else if (wdata[7:0] == `CFT_OP_FMT_TRACK) begin
                            if (trk_lba > max_lba) begin
                                err_reg[`CFT_ERR_ABT] <= 1'b1;
                                st_reg <= 8'h51;
                                ev     <= 2'b11;
                            end else begin
                                st_reg   <= 8'h80;
                                cur_lba  <= track_base(trk_lba);
                                sec_left <= `CFT_SEC_PER_TRK;
                                state    <= S_FMT;
                            end
                        end else begin
                            err_reg[`CFT_ERR_ABT] <= 1'b1;
                            st_reg <= 8'h51;
                            ev     <= 2'b11;
                        end
                    end
                end
                S_FREAD: begin
                    // wait a cycle for the registered cache read
                    if (scan == fill) begin
                        fill  <= {(CACHE_AW+1){1'b0}};
                        state <= S_DONE;
                    end else begin
                        state <= S_FWAIT;
                    end
                end
                S_FWAIT: begin
                    if (!m_busy && !m_start) begin
                        cur_lba <= ram_q[27:0];
                        m_start <= 1'b1;
                        state   <= S_MWAIT;
                    end
                end
                S_FMT: begin
                    if (sec_left == 8'h00) begin
                        cur_lba <= cur_lba - 28'h0000001;
                        state   <= S_DONE;
                    end else begin
                        m_start <= 1'b1;
                        state   <= S_MWAIT;
                    end
                end
                S_MWAIT: begin
                    if (m_done) begin
                        if (sec_left != 8'h00) begin
                            sec_left <= sec_left - 8'h01;
                            cur_lba  <= cur_lba + 28'h0000001;
                            state    <= S_FMT;
                        end else begin
                            slot  <= slot + 1'b1;
                            scan  <= scan + 1'b1;
                            state <= S_FREAD;
                        end
                    end
                end
                S_DONE: begin
                    if (devhead[`CFT_DH_LBA]) begin
                        secnum  <= cur_lba[7:0];
                        cyl_lo  <= cur_lba[15:8];
                        cyl_hi  <= cur_lba[23:16];
                        devhead <= {devhead[7:4], cur_lba[27:24]};
                    end
                    st_reg <= `CFT_ST_RESET;
                    ev     <= 2'b01;
                    state  <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, mask and output
    // ----------------------------------------------------------------
    // set wins over write-one-to-clear in the same cycle
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= 2'b00;
            irq_mask <= 2'b00;
            irq      <= 1'b0;
        end else begin
            if (wr && addr == `CFT_A_IRQ_MASK) begin
                irq_mask <= wdata[1:0];
            end
            if (wr && addr == `CFT_A_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~wdata[1:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            irq <= |((irq_stat | ev) & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // read port and flopped outputs
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata      <= 32'h00000000;
            cache_full <= 1'b0;
            media_we   <= 1'b0;
            media_lba  <= 28'h0000000;
            media_zero <= 1'b0;
        end else begin
            cache_full <= fill[CACHE_AW];
            media_we   <= m_done;
            media_lba  <= m_lba;
            media_zero <= m_zero;
            rdata      <= 32'h00000000;
            if (rd) begin
                if (addr == `CFT_A_ERROR) begin
                    rdata <= {24'h000000, err_reg};
                end else if (addr == `CFT_A_SECNUM) begin
                    rdata <= {24'h000000, secnum};
                end else if (addr == `CFT_A_CYL_LO) begin
                    rdata <= {24'h000000, cyl_lo};
                end else if (addr == `CFT_A_CYL_HI) begin
                    rdata <= {24'h000000, cyl_hi};
                end else if (addr == `CFT_A_DEVHEAD) begin
                    rdata <= {24'h000000, devhead};
                end else if (addr == `CFT_A_STATUS) begin
                    rdata <= {24'h000000, st_reg};
                end else if (addr == `CFT_A_IRQ_STAT) begin
                    rdata <= {30'h00000000, irq_stat};
                end else if (addr == `CFT_A_IRQ_MASK) begin
                    rdata <= {30'h00000000, irq_mask};
                end else if (addr == `CFT_A_MAX_LBA) begin
                    rdata <= {4'h0, max_lba};
                end
            end
        end
    end
endmodule

// *** bench/cft_cmd_exec_checker.sv ***
/*
 * port assertions for the flush / track-format command executor.
 * assumes a bind onto cft_cmd_exec, one clock, async active-low reset.
 */
`timescale 1ns/1ps
module cft_cmd_exec_checker (
    input wire        ref_clk,
    input wire        rst_n,
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire        cache_put,
    input wire [27:0] cache_lba,
    input wire [31:0] rdata,
    input wire        irq,
    input wire        cache_full,
    input wire        media_we,
    input wire [27:0] media_lba,
    input wire        media_zero
);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    reg [6:0]  zcnt;
    reg [27:0] zlast;
    reg [7:0]  op;

    // zero-fill pulses since the last command, so each track is seen alone
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            zcnt <= 7'h00;
            zlast <= 28'h0;
            op <= 8'h00;
        end else begin
            if (wr && addr == 8'h14) begin
                op <= wdata[7:0];
                zcnt <= 7'h00;
            end else if (media_we && media_zero) begin
                zcnt <= zcnt + 7'h01;
            end
            if (media_we) begin
                zlast <= media_lba;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside read slot");
    unmapped_zero_a: assert property (rd && addr == 8'h30 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    status_fault_a: assert property (rd && addr == 8'h18 |=> (rdata & 32'hffffff24) == 32'h0)
        else $error("status shows fault or stray bits");
    error_bits_a: assert property (rd && addr == 8'h00 |=> (rdata & 32'hffffffeb) == 32'h0)
        else $error("error register has stray bits");
    mask_quiet_a: assert property ((wr && addr == 8'h20 && wdata[1:0] == 2'b00)
        ##1 !(wr && addr == 8'h20) |=> !irq)
        else $error("irq high with mask cleared");
    we_pulse_a: assert property (media_we |=> !media_we)
        else $error("media write not a single pulse");
    fmt_seq_a: assert property (media_we && media_zero && zcnt != 7'h00
        |-> media_lba == zlast + 28'h1)
        else $error("format sectors not consecutive");
    fmt_count_a: assert property (media_we && media_zero |-> zcnt < 7'd63)
        else $error("format wrote more than one track");
    flush_nozero_a: assert property (media_we && (op == 8'he7 || op == 8'hea)
        |-> !media_zero)
        else $error("flush wrote zero fill");
endmodule
bind cft_cmd_exec cft_cmd_exec_checker cft_cmd_exec_checker_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .cache_put(cache_put),
    .cache_lba(cache_lba), .rdata(rdata), .irq(irq), .cache_full(cache_full),
    .media_we(media_we), .media_lba(media_lba), .media_zero(media_zero));

// *** bench/cft_host_model.sv ***
/*
 * host adapter model: register cycles, cache entry and task-file loading.
 * assumes one clock shared with the executor; strobes last one cycle.
 */
`timescale 1ns/1ps
`include "cft_consts.vh"
module cft_host_model (
    input  wire        ref_clk,
    input  wire [31:0] rdata,
    output reg  [7:0]  addr,
    output reg  [31:0] wdata,
    output reg         wr,
    output reg         rd,
    output reg         cache_put,
    output reg  [27:0] cache_lba
);
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // quiet bus from time zero so nothing is taken during reset
    initial begin
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        cache_put = 1'b0;
        cache_lba = 28'h0;
    end

    task wr_reg(input [7:0] a, input [31:0] d);
        begin
            @(posedge ref_clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge ref_clk);
            wr <= 1'b0;
            #1;
        end
    endtask

    // data stand only in the cycle after the strobe, so sample there
    task rd_reg(input [7:0] a, output [31:0] d);
        begin
            @(posedge ref_clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge ref_clk);
            rd <= 1'b0;
            #1;
            d = rdata;
        end
    endtask

    task put(input [27:0] lba);
        begin
            @(posedge ref_clk);
            cache_put <= 1'b1;
            cache_lba <= lba;
            @(posedge ref_clk);
            cache_put <= 1'b0;
            #1;
        end
    endtask

    // bounded poll; a stuck busy bit shows up in the caller's status check
    task wait_idle(output [31:0] st);
        integer n;
        begin
            st = 32'h80;
            for (n = 0; n < 500 && st[7]; n = n + 1) rd_reg(`CFT_A_STATUS, st);
        end
    endtask

    // ------------------------------------------------------------
    // track selection; no format table is ever sent
    // ------------------------------------------------------------
    task load_lba(input [27:0] lba);
        begin
            wr_reg(`CFT_A_SECNUM, {24'h0, lba[7:0]});
            wr_reg(`CFT_A_CYL_LO, {24'h0, lba[15:8]});
            wr_reg(`CFT_A_CYL_HI, {24'h0, lba[23:16]});
            wr_reg(`CFT_A_DEVHEAD, {24'h0, 4'he, lba[27:24]});
        end
    endtask

    task load_chs(input [15:0] cyl, input [3:0] head);
        begin
            wr_reg(`CFT_A_CYL_LO, {24'h0, cyl[7:0]});
            wr_reg(`CFT_A_CYL_HI, {24'h0, cyl[15:8]});
            wr_reg(`CFT_A_DEVHEAD, {24'h0, 4'ha, head});
        end
    endtask
endmodule

// *** bench/tb.sv ***
/*
 * self-checking bench: flush forms, lba and chs track format, aborts, irq.
 * assumes the host model drives the bus; SEC_CYC shortened to 2.
 */
`timescale 1ns/1ps
`include "cft_consts.vh"
module tb;
    reg         ref_clk;
    reg         rst_n;
    wire [7:0]  addr;
    wire [31:0] wdata;
    wire        wr;
    wire        rd;
    wire        cache_put;
    wire [27:0] cache_lba;
    wire [31:0] rdata;
    wire        irq;
    wire        cache_full;
    wire        media_we;
    wire [27:0] media_lba;
    wire        media_zero;
    integer     fails;
    integer     cmp_count;
    integer     cycles;
    integer     i;
    integer     n;
    reg [31:0]  v;
    reg [31:0]  sum;
    reg [27:0]  mlba[$];
    reg         mzero[$];

    cft_cmd_exec #(.SEC_CYC(2)) cft_cmd_exec_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .cache_put(cache_put),
        .cache_lba(cache_lba), .rdata(rdata), .irq(irq), .cache_full(cache_full),
        .media_we(media_we), .media_lba(media_lba), .media_zero(media_zero));
    cft_host_model cft_host_model_inst (.ref_clk(ref_clk), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .cache_put(cache_put), .cache_lba(cache_lba));

    // ------------------------------------------------------------
    // clock, media monitor, timeout
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // every media write is logged so order and count can be judged later
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (media_we === 1'b1) begin
            mlba.push_back(media_lba);
            mzero.push_back(media_zero);
        end
        if (cycles == 20000) begin
            fails = fails + 1;
            report_and_stop;
        end
    end

    // ------------------------------------------------------------
    // checking tasks
    // ------------------------------------------------------------
    task check(input [8*10-1:0] what, input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task report_and_stop;
        begin
            if (fails == 0 && cmp_count > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // runs one command and checks the status, error and irq it leaves
    task run_cmd(input [7:0] op, input [7:0] st, input [7:0] er, input [1:0] ev);
        begin
            mlba.delete();
            mzero.delete();
            cft_host_model_inst.wr_reg(`CFT_A_COMMAND, {24'h0, op});
            cft_host_model_inst.wait_idle(v);
            check("status", v, {24'h0, st});
            cft_host_model_inst.rd_reg(`CFT_A_ERROR, v);
            check("error", v, {24'h0, er});
            cft_host_model_inst.rd_reg(`CFT_A_IRQ_STAT, v);
            check("irq_stat", v, {30'h0, ev});
            check("irq", irq, 1);
            cft_host_model_inst.wr_reg(`CFT_A_IRQ_STAT, 32'h3);
            cft_host_model_inst.rd_reg(`CFT_A_IRQ_STAT, v);
            check("irq clr", {v[31:1], irq}, 0);
        end
    endtask

    // one whole track of zero fill from the first sector b
    task fmt_check(input [27:0] b);
        begin
            run_cmd(`CFT_OP_FMT_TRACK, 8'h50, 8'h00, 2'b01);
            check("fmt count", mlba.size(), 63);
            for (n = 0; n < 63; n = n + 1) begin
                check("fmt lba", mlba[n], b + n);
                check("fmt zero", mzero[n], 1);
            end
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        fails = 0;
        cmp_count = 0;
        cycles = 0;
        rst_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        cft_host_model_inst.rd_reg(`CFT_A_STATUS, v);
        check("st reset", v, 32'h50);
        cft_host_model_inst.rd_reg(`CFT_A_MAX_LBA, v);
        check("max reset", v, 32'h0fffffff);
        cft_host_model_inst.rd_reg(8'h30, v);
        check("unmapped", v, 0);
        cft_host_model_inst.wr_reg(`CFT_A_IRQ_MASK, 32'h3);
        // short flush, then a full cache through the extended form
        for (i = 0; i < 2; i = i + 1) begin
            sum = 0;
            for (n = 0; n < (i ? 16 : 3); n = n + 1) begin
                cft_host_model_inst.put(28'h100 + n * 7);
                sum = sum + 28'h100 + n * 7;
            end
            @(posedge ref_clk);
            #1;
            check("full", cache_full, i);
            run_cmd(i ? `CFT_OP_FLUSH_EXT : `CFT_OP_FLUSH, 8'h50, 8'h00, 2'b01);
            check("flushed", mlba.size(), i ? 16 : 3);
            v = 0;
            for (n = 0; n < mlba.size(); n = n + 1) v = v + mlba[n];
            check("flush sum", v, sum);
            check("drained", cache_full, 0);
        end
        // lba mode: track holding 0x12345 starts at 0x12321
        cft_host_model_inst.load_lba(28'h0012345);
        fmt_check(28'h0012345 - 28'h0012345 % 63);
        cft_host_model_inst.rd_reg(`CFT_A_SECNUM, v);
        check("ret sec", v, 32'h5f);
        cft_host_model_inst.rd_reg(`CFT_A_CYL_LO, v);
        check("ret cyl lo", v, 32'h23);
        cft_host_model_inst.rd_reg(`CFT_A_CYL_HI, v);
        check("ret cyl hi", v, 32'h01);
        // chs mode: cylinder 2, head 3 of 15 heads
        cft_host_model_inst.load_chs(16'h0002, 4'h3);
        fmt_check((2 * 15 + 3) * 63);
        // out-of-range track and an unknown opcode both abort
        cft_host_model_inst.wr_reg(`CFT_A_MAX_LBA, 32'h100);
        cft_host_model_inst.load_lba(28'h0000200);
        run_cmd(`CFT_OP_FMT_TRACK, 8'h51, 8'h04, 2'b11);
        check("no write", mlba.size(), 0);
        run_cmd(8'h00, 8'h51, 8'h04, 2'b11);
        report_and_stop;
    end
endmodule
